/* hw/rtcb_core.sv */
// What the document asks of this block and of its host
// R1 - minute match: off bit 7, BCD minute
// R2 - hour match: off bit 7, BCD hour
// R3 - day match: off bit 7, BCD day
// R4 - weekday match: off bit 7, weekday 0-6
// R5 - tick select: 4096, 64, 1, 1/60 Hz
// R6 - setup bit 7 runs countdown, reset off
// R7 - decrement per tick, flag each countdown end
// R8 - done flag holds until host clears
// R9 - interrupt pin pulse or level mode
// R10 - counter reads return live value
// R11 - period is count over tick rate
// R12 - host reads counter twice to agree
// R13 - host picks 1/60 Hz when idle
// R14 - square wave enable, pin floats when off
// R15 - square wave rate select, 32.768 kHz default
// R16 - alarm flag sets on advance into match
// R17 - flag write ANDs, zero clears
// R18 - gates OR flags onto interrupt pin
// R19 - zero count keeps timer stopped
// R20 - reload last written value, keep counting
// R21 - BCD compare on each time advance
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module rtcb_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rtcb_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic xtal_in,
  input wire logic time_step,
  input wire logic [6:0] now_minute,
  input wire logic [5:0] now_hour,
  input wire logic [5:0] now_day,
  input wire logic [2:0] now_weekday,
  output logic irq_pin_o,
  output logic irq_pin_oe,
  output logic square_wave_pin_o,
  output logic square_wave_pin_oe
);

  rtcb_tick_if tk ();

  rtcb_prescale u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .xtal_in(xtal_in),
    .tk(tk)
  );

  localparam int PW_W = rtcb_pkg::TICK_64_BITS + 1;
  localparam logic [PW_W-1:0] PW_4K = PW_W'(1 << rtcb_pkg::TICK_4K_BITS);
  localparam logic [PW_W-1:0] PW_64 = PW_W'(1 << rtcb_pkg::TICK_64_BITS);

  logic [7:0] min_match_r;
  logic [7:0] hour_match_r;
  logic [7:0] day_match_r;
  logic [7:0] wday_match_r;
  logic [7:0] sqw_setup_r;
  logic [7:0] cd_setup_r;
  logic [7:0] cd_count_r;
  logic [7:0] cd_reload_r;
  logic irq_pulse_select_r;
  logic alarm_irq_gate_r;
  logic countdown_irq_gate_r;
  logic alarm_match_flag_r;
  logic countdown_done_flag_r;
  logic pulse_r;
  logic prev_match_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_oe_r;
  logic sqw_oe_r;

  logic [rtcb_pkg::IDX_W-1:0] idx;
  logic setup_ph;
  logic wr_go;
  logic [7:0] wbyte;
  logic [7:0] rd_nxt;
  logic err_nxt;
  logic countdown_run;
  logic [1:0] countdown_tick_select;
  logic cd_tick;
  logic cd_done;
  logic xtal_rise;
  logic xtal_prev_r;
  logic [PW_W-1:0] pw_cnt_r;
  logic [PW_W-1:0] pw_len;
  logic match_c;
  logic alarm_set;
  logic wave_sel;
  logic flags_wr;
  logic count_wr;

  assign idx = paddr[rtcb_pkg::ADDR_W-1:2];
  assign setup_ph = psel & ~penable;
  // a write lands only at the access edge, and only for a mapped word
  assign wr_go = psel & penable & pready_r & pwrite & ~pslverr_r & pstrb[0];
  assign wbyte = pwdata[7:0];
  assign flags_wr = wr_go & (idx == rtcb_pkg::IDX_FLAGS);
  assign count_wr = wr_go & (idx == rtcb_pkg::IDX_CD_VALUE);
  assign countdown_run = cd_setup_r[rtcb_pkg::RUN_BIT];
  assign countdown_tick_select = cd_setup_r[1:0];

  // read mux and unmapped decode
  always_comb begin
    rd_nxt = 8'h00;
    err_nxt = (paddr[1:0] != 2'h0);
    unique case (idx)
      rtcb_pkg::IDX_FLAGS: begin
        rd_nxt[rtcb_pkg::FL_PULSE_BIT] = irq_pulse_select_r;
        rd_nxt[rtcb_pkg::FL_ALARM_BIT] = alarm_match_flag_r;
        rd_nxt[rtcb_pkg::FL_DONE_BIT] = countdown_done_flag_r;
        rd_nxt[rtcb_pkg::FL_AGATE_BIT] = alarm_irq_gate_r;
        rd_nxt[rtcb_pkg::FL_CGATE_BIT] = countdown_irq_gate_r;
      end
      rtcb_pkg::IDX_MIN_MATCH: rd_nxt = min_match_r;
      rtcb_pkg::IDX_HOUR_MATCH: rd_nxt = hour_match_r;
      rtcb_pkg::IDX_DAY_MATCH: rd_nxt = day_match_r;
      rtcb_pkg::IDX_WDAY_MATCH: rd_nxt = wday_match_r;
      rtcb_pkg::IDX_SQW: rd_nxt = sqw_setup_r;
      rtcb_pkg::IDX_CD_SETUP: rd_nxt = cd_setup_r;
      rtcb_pkg::IDX_CD_VALUE: rd_nxt = cd_count_r; // R10
      default: err_nxt = 1'b1;
    endcase
  end

  // one wait-free access phase; answer registered during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup_ph;
      if (setup_ph) begin
        pslverr_r <= err_nxt;
        prdata_r <= (err_nxt || pwrite) ? 32'h0000_0000 : {24'h00_0000, rd_nxt};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      min_match_r <= rtcb_pkg::MATCH_RST;
      hour_match_r <= rtcb_pkg::MATCH_RST;
      day_match_r <= rtcb_pkg::MATCH_RST;
      wday_match_r <= rtcb_pkg::MATCH_RST;
    end else if (wr_go) begin
      if (idx == rtcb_pkg::IDX_MIN_MATCH) begin
        min_match_r <= wbyte & rtcb_pkg::MIN_WMASK; // R1
      end
      if (idx == rtcb_pkg::IDX_HOUR_MATCH) begin
        hour_match_r <= wbyte & rtcb_pkg::HOUR_WMASK; // R2
      end
      if (idx == rtcb_pkg::IDX_DAY_MATCH) begin
        day_match_r <= wbyte & rtcb_pkg::DAY_WMASK; // R3
      end
      if (idx == rtcb_pkg::IDX_WDAY_MATCH) begin
        wday_match_r <= wbyte & rtcb_pkg::WDAY_WMASK; // R4
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sqw_setup_r <= rtcb_pkg::SQW_RST;
      cd_setup_r <= rtcb_pkg::CD_SETUP_RST;
    end else if (wr_go) begin
      if (idx == rtcb_pkg::IDX_SQW) begin
        sqw_setup_r <= wbyte & rtcb_pkg::SQW_WMASK; // R14 R15
      end
      if (idx == rtcb_pkg::IDX_CD_SETUP) begin
        cd_setup_r <= wbyte & rtcb_pkg::CD_WMASK; // R6
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pulse_select_r <= 1'b0;
      alarm_irq_gate_r <= 1'b0;
      countdown_irq_gate_r <= 1'b0;
    end else if (flags_wr) begin
      irq_pulse_select_r <= wbyte[rtcb_pkg::FL_PULSE_BIT];
      alarm_irq_gate_r <= wbyte[rtcb_pkg::FL_AGATE_BIT];
      countdown_irq_gate_r <= wbyte[rtcb_pkg::FL_CGATE_BIT];
    end
  end

  // countdown tick source
  always_comb begin
    unique case (countdown_tick_select)
      rtcb_pkg::SEL_4K: cd_tick = tk.tick_4k; // R5
      rtcb_pkg::SEL_64: cd_tick = tk.tick_64;
      rtcb_pkg::SEL_1S: cd_tick = tk.tick_1s;
      rtcb_pkg::SEL_60S: cd_tick = tk.tick_60s;
    endcase
  end

  // the tick that finds a count of one ends a period of n ticks
  assign cd_done = countdown_run & cd_tick & (cd_count_r == 8'h01) & ~count_wr; // R7 R11

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cd_count_r <= rtcb_pkg::CD_VALUE_RST;
      cd_reload_r <= rtcb_pkg::CD_VALUE_RST;
    end else if (count_wr) begin
      cd_count_r <= wbyte;
      cd_reload_r <= wbyte;
    end else if (cd_done) begin
      cd_count_r <= cd_reload_r; // R20
    end else if (countdown_run && cd_tick && cd_count_r != 8'h00) begin // R19
      cd_count_r <= cd_count_r - 8'h01; // R7
    end
  end

  // hardware set wins over a clearing write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      countdown_done_flag_r <= 1'b0;
    end else if (cd_done) begin
      countdown_done_flag_r <= 1'b1; // R7
    end else if (flags_wr && !wbyte[rtcb_pkg::FL_DONE_BIT]) begin
      countdown_done_flag_r <= 1'b0; // R8 R17
    end
  end

  // width in crystal rises: one tick, or 1/64 s on slow sources; halved for a count
  // of one on the fast sources, else back-to-back ends would hold the pin for good
  assign pw_len = ((countdown_tick_select == rtcb_pkg::SEL_4K) ? PW_4K : PW_64)
    >> (cd_reload_r == 8'h01 && countdown_tick_select != rtcb_pkg::SEL_1S
        && countdown_tick_select != rtcb_pkg::SEL_60S); // R9
  assign xtal_rise = tk.wave_32k & ~xtal_prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_prev_r <= 1'b0;
      pulse_r <= 1'b0;
      pw_cnt_r <= '0;
    end else begin
      xtal_prev_r <= tk.wave_32k;
      if (cd_done) begin
        pulse_r <= 1'b1;
        pw_cnt_r <= pw_len;
      end else if (pulse_r && xtal_rise) begin
        pulse_r <= (pw_cnt_r != '0);
        pw_cnt_r <= pw_cnt_r - 1'b1;
      end
    end
  end

  // no comparison enabled means no alarm at all
  assign match_c = ~(min_match_r[7] & hour_match_r[7] & day_match_r[7] & wday_match_r[7])
    & (min_match_r[7] | (now_minute == min_match_r[6:0]))
    & (hour_match_r[7] | (now_hour == hour_match_r[5:0]))
    & (day_match_r[7] | (now_day == day_match_r[5:0]))
    & (wday_match_r[7] | (now_weekday == wday_match_r[2:0])); // R21
  assign alarm_set = time_step & match_c & ~prev_match_r; // R16

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_match_r <= 1'b0;
    end else if (time_step) begin
      prev_match_r <= match_c; // R21
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_match_flag_r <= 1'b0;
    end else if (alarm_set) begin
      alarm_match_flag_r <= 1'b1; // R16
    end else if (flags_wr && !wbyte[rtcb_pkg::FL_ALARM_BIT]) begin
      alarm_match_flag_r <= 1'b0; // R17
    end
  end

  // open-drain pin: enable high pulls the line low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_oe_r <= 1'b0;
    end else begin
      irq_oe_r <= (alarm_irq_gate_r & alarm_match_flag_r)
        | (countdown_irq_gate_r
           & (irq_pulse_select_r ? pulse_r : countdown_done_flag_r)); // R9 R18
    end
  end

  always_comb begin
    unique case (sqw_setup_r[1:0])
      2'h0: wave_sel = tk.wave_32k; // R15
      2'h1: wave_sel = tk.wave_1k;
      2'h2: wave_sel = tk.wave_32;
      2'h3: wave_sel = tk.wave_1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sqw_oe_r <= 1'b0;
    end else begin
      sqw_oe_r <= sqw_setup_r[rtcb_pkg::ON_BIT] & ~wave_sel; // R14
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq_pin_o = 1'b0;
  assign irq_pin_oe = irq_oe_r;
  assign square_wave_pin_o = 1'b0;
  assign square_wave_pin_oe = sqw_oe_r;

  a_done_sticky : assert property (@(posedge pclk) disable iff (!presetn) // R8
    countdown_done_flag_r && !(flags_wr && !wbyte[rtcb_pkg::FL_DONE_BIT])
    |=> countdown_done_flag_r)
    else $error("countdown done flag dropped without a clearing write");

  a_and_write_keeps : assert property (@(posedge pclk) disable iff (!presetn) // R17
    flags_wr && wbyte[rtcb_pkg::FL_ALARM_BIT] && alarm_match_flag_r
    |=> alarm_match_flag_r)
    else $error("writing one cleared the alarm flag");

  a_zero_stops : assert property (@(posedge pclk) disable iff (!presetn) // R19
    cd_count_r == 8'h00 && !count_wr |=> cd_count_r == 8'h00)
    else $error("countdown moved from zero");

  a_reload_period : assert property (@(posedge pclk) disable iff (!presetn) // R20
    cd_done |=> cd_count_r == $past(cd_reload_r) && countdown_done_flag_r)
    else $error("countdown end did not reload and flag");

  a_count_step : assert property (@(posedge pclk) disable iff (!presetn) // R7
    countdown_run && cd_tick && cd_count_r > 8'h01 && !count_wr
    |=> cd_count_r == $past(cd_count_r) - 8'h01)
    else $error("countdown did not decrement by one");

  a_idle_hold : assert property (@(posedge pclk) disable iff (!presetn) // R6
    !countdown_run && !count_wr |=> $stable(cd_count_r))
    else $error("disabled countdown changed");

  a_sqw_float : assert property (@(posedge pclk) disable iff (!presetn) // R14
    !sqw_setup_r[rtcb_pkg::ON_BIT] |=> !square_wave_pin_oe)
    else $error("square wave pin driven while off");

  a_irq_level : assert property (@(posedge pclk) disable iff (!presetn) // R18
    alarm_irq_gate_r && alarm_match_flag_r |=> irq_pin_oe)
    else $error("gated alarm flag not on interrupt pin");

  a_live_read : assert property (@(posedge pclk) disable iff (!presetn) // R10
    setup_ph && !pwrite && paddr == {rtcb_pkg::IDX_CD_VALUE, 2'h0}
    |=> pready && prdata[7:0] == $past(cd_count_r))
    else $error("counter read not the live value");

  a_alarm_edge : assert property (@(posedge pclk) disable iff (!presetn) // R16
    alarm_set |=> alarm_match_flag_r ##1 !alarm_set)
    else $error("alarm match did not set the flag");

endmodule : rtcb_core

`default_nettype wire

/* hw/rtcb_pkg.sv */
package rtcb_pkg;

  // bus geometry: data in the low byte of each aligned word
  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FLAGS = 6'h01;
  localparam logic [IDX_W-1:0] IDX_MIN_MATCH = 6'h09;
  localparam logic [IDX_W-1:0] IDX_HOUR_MATCH = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_DAY_MATCH = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_WDAY_MATCH = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_SQW = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_CD_SETUP = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_CD_VALUE = 6'h0F;

  // writable bits; the rest read as zero
  localparam logic [7:0] MIN_WMASK = 8'hFF;
  localparam logic [7:0] HOUR_WMASK = 8'hBF;
  localparam logic [7:0] DAY_WMASK = 8'hBF;
  localparam logic [7:0] WDAY_WMASK = 8'h87;
  localparam logic [7:0] SQW_WMASK = 8'h83;
  localparam logic [7:0] CD_WMASK = 8'h83;

  // reset values
  localparam logic [7:0] MATCH_RST = 8'h80;
  localparam logic [7:0] SQW_RST = 8'h80;
  localparam logic [7:0] CD_SETUP_RST = 8'h03;
  localparam logic [7:0] CD_VALUE_RST = 8'h00;

  // field positions
  localparam int OFF_BIT = 7;
  localparam int RUN_BIT = 7;
  localparam int ON_BIT = 7;
  localparam int FL_PULSE_BIT = 4;
  localparam int FL_ALARM_BIT = 3;
  localparam int FL_DONE_BIT = 2;
  localparam int FL_AGATE_BIT = 1;
  localparam int FL_CGATE_BIT = 0;

  // tick and rate selections
  localparam logic [1:0] SEL_4K = 2'h0;
  localparam logic [1:0] SEL_64 = 2'h1;
  localparam logic [1:0] SEL_1S = 2'h2;
  localparam logic [1:0] SEL_60S = 2'h3;

  // prescaler: crystal edges per tick are two to these powers
  localparam int PRE_W = 15;
  localparam int TICK_4K_BITS = 3;
  localparam int TICK_64_BITS = 9;
  localparam int SQW_1K_BIT = 4;
  localparam int SQW_32_BIT = 9;
  localparam int SQW_1_BIT = 14;
  localparam logic [5:0] SECS_PER_MIN_LAST = 6'h3B;

endpackage : rtcb_pkg

/* hw/rtcb_tick_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface rtcb_tick_if;
  logic tick_4k;
  logic tick_64;
  logic tick_1s;
  logic tick_60s;
  logic wave_32k;
  logic wave_1k;
  logic wave_32;
  logic wave_1;

  modport src (output tick_4k, output tick_64, output tick_1s, output tick_60s,
               output wave_32k, output wave_1k, output wave_32, output wave_1);
  modport snk (input tick_4k, input tick_64, input tick_1s, input tick_60s,
               input wave_32k, input wave_1k, input wave_32, input wave_1);
endinterface : rtcb_tick_if

`default_nettype wire

/* hw/rtcb_prescale.sv */
`timescale 1ns/1ps
`default_nettype none

module rtcb_prescale (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic xtal_in,
  rtcb_tick_if.src tk
);

  logic [2:0] sync_r;
  logic xtal_lvl_r;
  logic [rtcb_pkg::PRE_W-1:0] div_r;
  logic [5:0] sec_r;
  logic rise;
  logic sec_end;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], xtal_in};
    end
  end

  // level changes only once the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_lvl_r <= 1'b0;
    end else if (sync_r[1] == sync_r[2]) begin
      xtal_lvl_r <= sync_r[2];
    end
  end

  assign rise = sync_r[1] & sync_r[2] & ~xtal_lvl_r;
  assign sec_end = rise & (&div_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
    end else if (rise) begin
      div_r <= div_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_r <= 6'h00;
    end else if (sec_end) begin
      sec_r <= (sec_r == rtcb_pkg::SECS_PER_MIN_LAST) ? 6'h00 : sec_r + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tk.tick_4k <= 1'b0;
      tk.tick_64 <= 1'b0;
      tk.tick_1s <= 1'b0;
      tk.tick_60s <= 1'b0;
    end else begin
      tk.tick_4k <= rise & (&div_r[rtcb_pkg::TICK_4K_BITS-1:0]);
      tk.tick_64 <= rise & (&div_r[rtcb_pkg::TICK_64_BITS-1:0]);
      tk.tick_1s <= sec_end;
      tk.tick_60s <= sec_end & (sec_r == rtcb_pkg::SECS_PER_MIN_LAST);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tk.wave_32k <= 1'b0;
      tk.wave_1k <= 1'b0;
      tk.wave_32 <= 1'b0;
      tk.wave_1 <= 1'b0;
    end else begin
      tk.wave_32k <= xtal_lvl_r;
      tk.wave_1k <= div_r[rtcb_pkg::SQW_1K_BIT];
      tk.wave_32 <= div_r[rtcb_pkg::SQW_32_BIT];
      tk.wave_1 <= div_r[rtcb_pkg::SQW_1_BIT];
    end
  end

  a_tick_4k_rate : assert property (@(posedge pclk) disable iff (!presetn) // R5
    tk.tick_64 |-> tk.tick_4k)
    else $error("64 Hz tick without coincident 4 kHz tick");

endmodule : rtcb_prescale

`default_nettype wire

/* verif/rtcb_time_src.sv */
`timescale 1ns/1ps
`default_nettype none

module rtcb_time_src (
  input wire logic pclk,
  output logic xtal_in,
  output logic time_step,
  output logic [6:0] now_minute,
  output logic [5:0] now_hour,
  output logic [5:0] now_day,
  output logic [2:0] now_weekday
);
  // crystal sped up to eight pclk periods; it runs free, as a crystal does
  initial xtal_in = 1'h0;
  always #200 xtal_in = ~xtal_in;
  initial begin
    time_step = 1'h0;
    now_minute = 7'h00;
    now_hour = 6'h12;
    now_day = 6'h07;
    now_weekday = 3'h3;
  end
  // time counters move in BCD, one step pulse for each advance
  task advance(input logic [6:0] m);
    @(posedge pclk);
    now_minute <= m;
    time_step <= 1'h1;
    @(posedge pclk);
    time_step <= 1'h0;
  endtask : advance
endmodule : rtcb_time_src

`default_nettype wire

/* verif/test_rtc_alarm_timer_clock_output.sv */
`timescale 1ns/1ps
`default_nettype none

module test_rtc_alarm_timer_clock_output;
  localparam logic [7:0] A_FLG = {rtcb_pkg::IDX_FLAGS, 2'h0};
  localparam logic [7:0] A_MIN = {rtcb_pkg::IDX_MIN_MATCH, 2'h0};
  localparam logic [7:0] A_HR = {rtcb_pkg::IDX_HOUR_MATCH, 2'h0};
  localparam logic [7:0] A_DAY = {rtcb_pkg::IDX_DAY_MATCH, 2'h0};
  localparam logic [7:0] A_WD = {rtcb_pkg::IDX_WDAY_MATCH, 2'h0};
  localparam logic [7:0] A_SQW = {rtcb_pkg::IDX_SQW, 2'h0};
  localparam logic [7:0] A_CDS = {rtcb_pkg::IDX_CD_SETUP, 2'h0};
  localparam logic [7:0] A_CDV = {rtcb_pkg::IDX_CD_VALUE, 2'h0};
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic er;
  } rtcb_row_t;
  logic pclk, presetn, psel, penable, pwrite, xtal_in, time_step;
  logic pready, pslverr, irq_pin_o, irq_pin_oe, square_wave_pin_o, square_wave_pin_oe;
  logic [7:0] paddr, got, g1;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [6:0] now_minute;
  logic [5:0] now_hour, now_day;
  logic [2:0] now_weekday;
  logic er, seen;
  int n_errors = 0;
  int checks = 0;
  int n, c;
  rtcb_row_t rows [0:17] = '{
    '{1'h0, A_MIN, 8'h00, 8'h80, 1'h0},
    '{1'h0, A_HR, 8'h00, 8'h80, 1'h0},
    '{1'h0, A_DAY, 8'h00, 8'h80, 1'h0},
    '{1'h0, A_WD, 8'h00, 8'h80, 1'h0},
    '{1'h0, A_SQW, 8'h00, 8'h80, 1'h0},
    '{1'h0, A_CDS, 8'h00, 8'h03, 1'h0},
    '{1'h0, A_CDV, 8'h00, 8'h00, 1'h0},
    '{1'h0, A_FLG, 8'h00, 8'h00, 1'h0},
    '{1'h1, A_MIN, 8'hFF, 8'hFF, 1'h0},
    '{1'h1, A_HR, 8'hFF, 8'hBF, 1'h0},
    '{1'h1, A_DAY, 8'hFF, 8'hBF, 1'h0},
    '{1'h1, A_WD, 8'hFF, 8'h87, 1'h0},
    '{1'h1, A_SQW, 8'hFF, 8'h83, 1'h0},
    '{1'h1, A_CDS, 8'hFF, 8'h83, 1'h0},
    '{1'h1, A_CDV, 8'hFF, 8'hFF, 1'h0},
    '{1'h1, A_FLG, 8'hFF, 8'h13, 1'h0},
    '{1'h0, 8'h25, 8'h00, 8'h00, 1'h1},
    '{1'h0, 8'h40, 8'h00, 8'h00, 1'h1}
  };

  rtcb_core rtcb_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xtal_in(xtal_in), .time_step(time_step),
    .now_minute(now_minute), .now_hour(now_hour), .now_day(now_day),
    .now_weekday(now_weekday), .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe),
    .square_wave_pin_o(square_wave_pin_o), .square_wave_pin_oe(square_wave_pin_oe));
  rtcb_time_src rtcb_time_src_i (.pclk(pclk), .xtal_in(xtal_in), .time_step(time_step),
    .now_minute(now_minute), .now_hour(now_hour), .now_day(now_day),
    .now_weekday(now_weekday));

  initial pclk = 1'h0;
  always #25 pclk = ~pclk;

  task close_out;
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (pready !== 1'h1) chk(8'h00, 8'h01);
    got = prdata[7:0];
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'h0, a, 8'h00);
    chk(got, e);
  endtask : rd

  // bounded wait on the interrupt pin, n counts cycles
  task wait_irq(input logic lvl, input int lim);
    n = 0;
    while (irq_pin_oe !== lvl && n < lim) begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask : wait_irq

  task cnt_sq;
    logic prev;
    c = 0;
    prev = square_wave_pin_oe;
    repeat (800) begin
      @(posedge pclk);
      #1;
      if (square_wave_pin_oe !== prev) c++;
      prev = square_wave_pin_oe;
    end
  endtask : cnt_sq

  initial begin
    #3_000_000;
    n_errors++;
    close_out();
  end

  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      if (rows[i].wr) apb(1'h0, rows[i].a, 8'h00);
      chk(got, rows[i].e);
      chk({7'h0, er}, {7'h0, rows[i].er});
    end
    // 4 kHz countdown of 3, level mode
    wr(A_FLG, 8'h01);
    wr(A_CDV, 8'h03);
    wr(A_CDS, 8'h80);
    wait_irq(1'h1, 400);
    chk({7'h0, n >= 120 && n <= 200}, 8'h01);
    rd(A_FLG, 8'h05);
    seen = 1'h0;
    repeat (6) begin
      do begin
        apb(1'h0, A_CDV, 8'h00);
        g1 = got;
        apb(1'h0, A_CDV, 8'h00);
      end while (g1 !== got);
      chk({7'h0, got >= 8'h01 && got <= 8'h03}, 8'h01);
      if (got !== 8'h03) seen = 1'h1;
      repeat (17) @(posedge pclk);
    end
    chk({7'h0, seen}, 8'h01);
    rd(A_FLG, 8'h05);
    chk({7'h0, irq_pin_oe}, 8'h01);
    wr(A_CDS, 8'h03);
    wr(A_FLG, 8'h01);
    rd(A_FLG, 8'h01);
    chk({7'h0, irq_pin_oe}, 8'h00);
    // zero count never runs
    wr(A_CDV, 8'h00);
    wr(A_CDS, 8'h80);
    repeat (300) @(posedge pclk);
    rd(A_CDV, 8'h00);
    rd(A_FLG, 8'h01);
    // pulse mode: pin drops while the flag stays
    wr(A_FLG, 8'h11);
    wr(A_CDV, 8'h01);
    wait_irq(1'h1, 200);
    chk({7'h0, n < 200}, 8'h01);
    wait_irq(1'h0, 100);
    chk({7'h0, n < 100}, 8'h01);
    rd(A_FLG, 8'h15);
    wr(A_CDS, 8'h03);
    // 64 Hz countdown of 2
    wr(A_FLG, 8'h01);
    wr(A_CDV, 8'h02);
    wr(A_CDS, 8'h81);
    wait_irq(1'h1, 9000);
    chk({7'h0, n >= 4000 && n <= 8300}, 8'h01);
    wr(A_CDS, 8'h03);
    wr(A_FLG, 8'h00);
    rd(A_FLG, 8'h00);
    // alarm on minute only
    wr(A_MIN, 8'h15);
    wr(A_FLG, 8'h02);
    rtcb_time_src_i.advance(7'h14);
    rd(A_FLG, 8'h02);
    rtcb_time_src_i.advance(7'h15);
    rd(A_FLG, 8'h0A);
    chk({7'h0, irq_pin_oe}, 8'h01);
    wr(A_FLG, 8'h09);
    rd(A_FLG, 8'h09);
    chk({7'h0, irq_pin_oe}, 8'h00);
    wr(A_FLG, 8'h02);
    rtcb_time_src_i.advance(7'h15);
    rd(A_FLG, 8'h02);
    rtcb_time_src_i.advance(7'h16);
    rtcb_time_src_i.advance(7'h15);
    rd(A_FLG, 8'h0A);
    // write without the low lane strobe is dropped
    pstrb <= 4'hE;
    wr(A_MIN, 8'h00);
    pstrb <= 4'hF;
    rd(A_MIN, 8'h15);
    // square wave: 32 kHz toggles every half crystal period, 1 kHz 32 times slower
    wr(A_SQW, 8'h80);
    cnt_sq();
    chk({7'h0, c >= 180 && c <= 220}, 8'h01);
    wr(A_SQW, 8'h81);
    cnt_sq();
    chk({7'h0, c >= 4 && c <= 8}, 8'h01);
    wr(A_SQW, 8'h01);
    // let the last wave level drain before counting edges
    repeat (2) @(posedge pclk);
    cnt_sq();
    chk(c[7:0], 8'h00);
    chk({7'h0, square_wave_pin_oe}, 8'h00);
    chk({6'h0, irq_pin_o, square_wave_pin_o}, 8'h00);
    // second reset in mid-run
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rd(A_CDS, 8'h03);
    rd(A_SQW, 8'h80);
    rd(A_MIN, 8'h80);
    close_out();
  end
endmodule : test_rtc_alarm_timer_clock_output

`default_nettype wire
